// [inc/standby_pkg.sv]
// constants, register layout and state codes for the standby wake timer
package standby_pkg;
    // register byte addresses
    localparam logic [31:0] STANDBY_CONTROL_OFFSET = 32'h0000_0000;
    localparam logic [31:0] POWER_STATUS_OFFSET = 32'h0000_0004;
    // standby_control field positions
    localparam int STANDBY_SELECT_BIT = 15;
    localparam int OUTPUT_ENABLE_BIT = 14;
    localparam int WAIT_SEL_LSB = 8;
    localparam int WAIT_SEL_W = 5;
    localparam int SLEEP_EXC_BIT = 7;
    localparam int CTRL_W = 16;
    // standby_control reset values
    localparam logic [4:0] WAIT_SEL_RESET = 5'h0f;
    localparam logic STANDBY_SELECT_RESET = 1'b0;
    localparam logic OUTPUT_ENABLE_RESET = 1'b1;
    localparam logic SLEEP_EXC_RESET = 1'b0;
    // selector codes with a defined wait
    localparam logic [4:0] SEL_64 = 5'h05;
    localparam logic [4:0] SEL_512 = 5'h06;
    localparam logic [4:0] SEL_1024 = 5'h07;
    localparam logic [4:0] SEL_2048 = 5'h08;
    localparam logic [4:0] SEL_4096 = 5'h09;
    localparam logic [4:0] SEL_16384 = 5'h0a;
    localparam logic [4:0] SEL_32768 = 5'h0b;
    localparam logic [4:0] SEL_65536 = 5'h0c;
    localparam logic [4:0] SEL_131072 = 5'h0d;
    localparam logic [4:0] SEL_262144 = 5'h0e;
    localparam logic [4:0] SEL_524288 = 5'h0f;
    // wait counter width and the short waits, in peripheral-clock states
    localparam int CNT_W = 20;
    localparam logic [19:0] WAIT_64 = 20'h0_0040;
    localparam logic [19:0] WAIT_512 = 20'h0_0200;
    localparam logic [19:0] WAIT_1024 = 20'h0_0400;
    localparam logic [19:0] WAIT_2048 = 20'h0_0800;
    localparam logic [19:0] WAIT_4096 = 20'h0_1000;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // power sequencer states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_STANDBY = 2'b10,
        ST_SETTLE = 2'b11
    } power_state_t;
endpackage

// [hw/settle_counter.sv]
// up-counter that times the oscillator settling wait
`timescale 1ns/1ns
module settle_counter
    import standby_pkg::*;
#(
    parameter int WIDTH = CNT_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic [WIDTH-1:0] length,
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] length_reg;
    logic busy_reg;
    logic done_reg;
    logic last;

    // length is latched so a register write mid-wait cannot shorten it
    assign last = (count_reg == length_reg - WIDTH'(1));
    assign busy = busy_reg;
    assign done = done_reg;

    // load from zero on start, one step per peripheral clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= '0;
            length_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (ce) begin
            done_reg <= 1'b0;
            if (start) begin
                count_reg <= '0;
                length_reg <= length;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                count_reg <= count_reg + WIDTH'(1);
                if (last) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
            end
        end
    end
endmodule

// [hw/lite_slave.sv]
// axi4-lite slave front end with a simple register access port
`timescale 1ns/1ns
module lite_slave
    import standby_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [31:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_full_reg;
    logic w_full_reg;
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_take;
    logic w_take;
    logic ar_take;

    // each channel is taken once its holding slot is empty and no response on its side is pending
    assign awready = ce && !aw_full_reg && !bvalid;
    assign wready = ce && !w_full_reg && !bvalid;
    assign arready = ce && !rvalid;
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign ar_take = arvalid && arready;
    // write lands one cycle after both halves are held
    assign wr_en = ce && aw_full_reg && w_full_reg && !bvalid;
    assign wr_addr = awaddr_reg;
    assign wr_data = wdata_reg;
    assign wr_strb = wstrb_reg;
    assign rd_addr = araddr;

    // write path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (ce) begin
            if (aw_take) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= awaddr;
            end
            if (w_take) begin
                w_full_reg <= 1'b1;
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            if (wr_en) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read path, data registered at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (ar_take) begin
                rvalid <= 1'b1;
                rdata <= rd_ok ? rd_data : 32'h0000_0000;
                rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

// [hw/standby_wake_timer.sv]
// standby control register, sleep sequencing and wake settling timer
//
// Overview of operation
// R1 - The five-bit wait selector sets how long resumption is held off after an external interrupt ends software standby.
// R2 - During settling the wait counter steps once per peripheral clock cycle.
// R3 - Codes 00101, 00110 and 00111 give 64, 512 and 1024 states; 00000 to 00100 and all 1xxxx codes are reserved.
// R4 - Codes 01000, 01001 and 01010 give 2048, 4096 and 16384 states.
// R5 - Codes 01011 to 01111 give 32768, 65536, 131072, 262144 and 524288 states in that order.
// R6 - The selector resets to 01111, the longest wait.
// R7 - Software picks a wait no shorter than the oscillator or pll settling time.
// R8 - With the sleep exception enable at 0 the sleep instruction enters a power-down state.
// R9 - With it at 1 the sleep instruction raises a sleep exception instead of powering down.
// R10 - Hardware never clears the sleep exception enable; it stays 1 after the exception.
// R11 - Writing 0 clears the sleep exception enable; it sits at bit 7 and resets to 0.
// R12 - Bit 13 always reads 0.
// R13 - Bits 6 to 0 always read 0.
// R14 - Standby select 0 makes sleep enter sleep mode, 1 enters software standby timed by the selector.
// R15 - Software clears standby select whenever it sets the sleep exception enable.
// R16 - On wake the counter loads zero, counts to the selected length, then releases the core.
`timescale 1ns/1ns
module standby_wake_timer
    import standby_pkg::*;
#(
    parameter int unsigned WAIT_16384 = 16384,
    parameter int unsigned WAIT_32768 = 32768,
    parameter int unsigned WAIT_65536 = 65536,
    parameter int unsigned WAIT_131072 = 131072,
    parameter int unsigned WAIT_262144 = 262144,
    parameter int unsigned WAIT_524288 = 524288
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,

    // register bus
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,

    // core side and wake pin
    input wire logic sleep_exec,
    input wire logic int_request,
    input wire logic ext_wake,

    // strobes and mode levels
    output logic sleep_exception,
    output logic sleep_mode,
    output logic standby_mode,
    output logic settling,
    output logic core_resume,
    output logic output_port_enable
);
    // standby_control fields
    logic standby_select_reg;
    logic output_enable_reg;
    logic [4:0] wait_select_reg;
    logic sleep_exception_enable_reg;
    logic [15:0] standby_control;

    // sequencer
    power_state_t state_reg;
    power_state_t state_next;
    logic sleep_exception_reg;
    logic core_resume_reg;
    logic ext_wake_meta_reg;
    logic ext_wake_sync_reg;
    // strobe conditions
    logic exc_go;
    logic resume_go;

    // bus access port
    logic wr_en;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    // decoded strobes
    logic wr_ctrl;
    logic wr_lo;
    logic wr_hi;
    logic rd_status;

    // settling timer
    // full width, so the longest wait fits
    logic [CNT_W-1:0] wait_len;
    logic cnt_start;
    logic cnt_busy;
    logic cnt_done;

    // bus front end, answers a read a clock after the take, a write two clocks after
    lite_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // address decode; the status word is read-only, so writes to it error
    assign wr_ok = (wr_addr == STANDBY_CONTROL_OFFSET);
    assign rd_status = (rd_addr == POWER_STATUS_OFFSET);
    assign rd_ok = (rd_addr == STANDBY_CONTROL_OFFSET) || rd_status;
    assign wr_ctrl = wr_en && wr_ok;

    // lane 1 holds bits 15..8, lane 0 bit 7
    assign wr_lo = wr_ctrl && wr_strb[0];
    assign wr_hi = wr_ctrl && wr_strb[1];

    // reserved bits 13 and 6..0 are not stored and read as zero
    assign standby_control = {standby_select_reg,
                              output_enable_reg,
                              1'b0, // see R12
                              wait_select_reg,
                              sleep_exception_enable_reg,
                              7'h00}; // see R13

    // status: state code in bits 1..0
    assign rd_data = rd_status
                   ? {30'h0000_0000, state_reg}
                   : {16'h0000, standby_control};

    // register writes; only software ever changes these bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            standby_select_reg <= STANDBY_SELECT_RESET;
            output_enable_reg <= OUTPUT_ENABLE_RESET;
            wait_select_reg <= WAIT_SEL_RESET; // see R6
            sleep_exception_enable_reg <= SLEEP_EXC_RESET; // see R11
        end else if (ce) begin
            if (wr_hi) begin
                standby_select_reg <= wr_data[STANDBY_SELECT_BIT];
                output_enable_reg <= wr_data[OUTPUT_ENABLE_BIT];
                wait_select_reg <= wr_data[WAIT_SEL_LSB +: WAIT_SEL_W];
            end

            if (wr_lo) begin
                sleep_exception_enable_reg <= wr_data[SLEEP_EXC_BIT]; // see R10, R11
            end
        end
    end

    // selector to wait length; reserved codes fall back to the longest wait,
    // erring on the side of a stable clock
    always_comb begin
        // long waits are parameters
        case (wait_select_reg) // see R1
            SEL_64: wait_len = WAIT_64; // see R3
            SEL_512: wait_len = WAIT_512; // see R3
            SEL_1024: wait_len = WAIT_1024; // see R3
            SEL_2048: wait_len = WAIT_2048; // see R4
            SEL_4096: wait_len = WAIT_4096; // see R4
            SEL_16384: wait_len = CNT_W'(WAIT_16384); // see R4
            SEL_32768: wait_len = CNT_W'(WAIT_32768); // see R5
            SEL_65536: wait_len = CNT_W'(WAIT_65536); // see R5
            SEL_131072: wait_len = CNT_W'(WAIT_131072); // see R5
            SEL_262144: wait_len = CNT_W'(WAIT_262144); // see R5
            SEL_524288: wait_len = CNT_W'(WAIT_524288); // see R5
            default: wait_len = CNT_W'(WAIT_524288); // see R3
        endcase
    end

    // external interrupt arrives from a pin, two flops before use
    // a wake shorter than a clock may be missed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_wake_meta_reg <= 1'b0;
            ext_wake_sync_reg <= 1'b0;
        end else if (ce) begin
            ext_wake_meta_reg <= ext_wake;
            ext_wake_sync_reg <= ext_wake_meta_reg;
        end
    end

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            // an enabled exception keeps the core running
            ST_RUN: begin
                if (sleep_exec && !sleep_exception_enable_reg) begin // see R8, R9
                    state_next = standby_select_reg ? ST_STANDBY : ST_SLEEP; // see R14
                end
            end

            // any interrupt or the pin ends sleep
            ST_SLEEP: begin
                if (int_request || ext_wake_sync_reg) begin
                    state_next = ST_RUN;
                end
            end

            ST_STANDBY: begin
                // only an external interrupt ends software standby
                if (ext_wake_sync_reg) begin
                    state_next = ST_SETTLE; // see R1, R14
                end
            end

            // the done strobe ends the wait
            ST_SETTLE: begin
                if (cnt_done) begin
                    state_next = ST_RUN; // see R16
                end
            end

            // unused code, back to run
            default: state_next = ST_RUN;
        endcase
    end

    // counter starts on the wake edge itself
    // reserved codes still give a full wait
    assign cnt_start = ce && (state_reg == ST_STANDBY) && ext_wake_sync_reg; // see R16

    // length is latched at start
    settle_counter #(
        .WIDTH(CNT_W)
    ) u_settle (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .start(cnt_start),
        .length(wait_len),
        .busy(cnt_busy),
        .done(cnt_done)
    ); // see R2

    // the exception leaves the state untouched
    assign exc_go = (state_reg == ST_RUN) && sleep_exec && sleep_exception_enable_reg; // see R9

    // resume on every return to run
    assign resume_go = (state_reg != ST_RUN) && (state_next == ST_RUN); // see R16

    // sequencer state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_RUN;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // registered so the core sees clean pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_exception_reg <= 1'b0;
            core_resume_reg <= 1'b0;
        end else if (ce) begin
            sleep_exception_reg <= exc_go;
            core_resume_reg <= resume_go;
        end
    end

    // mode outputs decoded from the state register
    assign sleep_mode = (state_reg == ST_SLEEP);
    assign standby_mode = (state_reg == ST_STANDBY) || (state_reg == ST_SETTLE);
    // low in the done cycle
    assign settling = (state_reg == ST_SETTLE) && cnt_busy;
    assign sleep_exception = sleep_exception_reg;
    assign core_resume = core_resume_reg;
    // used by pin drivers in standby
    assign output_port_enable = output_enable_reg;
endmodule

// [verif/standby_wake_chk.sv]
// port checker for the standby wake timer
`timescale 1ns/1ns
module standby_wake_chk
    import standby_pkg::*;
#(
    parameter int unsigned WAIT_16384 = 16384,
    parameter int unsigned WAIT_524288 = 524288
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_wake,
    input wire logic sleep_exec,
    input wire logic int_request,
    input wire logic sleep_exception,
    input wire logic sleep_mode,
    input wire logic standby_mode,
    input wire logic settling,
    input wire logic core_resume,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata
);
    localparam int MIN_WAIT = (WAIT_16384 < 64) ? WAIT_16384 : 64;
    localparam int MAX_WAIT = (WAIT_524288 > 4096) ? WAIT_524288 : 4096;
    int settle_len;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // length of the current settling wait, cleared between waits
    always_ff @(posedge aclk) begin
        if (!aresetn || !settling) begin
            settle_len <= 0;
        end else begin
            settle_len <= settle_len + 1;
        end
    end
    exc_pulse_a: assert property (sleep_exception |->
        $past(sleep_exec) && !sleep_mode && !standby_mode ##1 !sleep_exception)
        else $error("sleep exception without a sleep instruction");
    sleep_entry_a: assert property ($rose(sleep_mode) |-> $past(sleep_exec) && !standby_mode)
        else $error("sleep mode entered without a sleep instruction");
    standby_entry_a: assert property ($rose(standby_mode) |-> $past(sleep_exec) && !settling)
        else $error("standby entered without a sleep instruction");
    sleep_exit_a: assert property (sleep_mode && int_request |=> !sleep_mode && core_resume)
        else $error("interrupt did not end sleep mode");
    standby_hold_a: assert property (standby_mode && !settling && !$past(settling) && !ext_wake
        && !$past(ext_wake) && !$past(ext_wake, 2) |=> standby_mode)
        else $error("standby left without an external wake");
    resume_cause_a: assert property (core_resume |-> !$past(core_resume) &&
        ($past(settling) || $past(settling, 2) || $past(sleep_mode)))
        else $error("core released without a wake");
    settle_min_a: assert property ($fell(settling) |-> settle_len + 2 >= MIN_WAIT)
        else $error("settling wait too short");
    settle_max_a: assert property (settling |-> settle_len <= MAX_WAIT + 2)
        else $error("settling wait too long");
    settle_mode_a: assert property (settling |-> standby_mode && !sleep_mode)
        else $error("settling outside standby");
    read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped before acceptance");
endmodule
bind standby_wake_timer standby_wake_chk #(.WAIT_16384(WAIT_16384), .WAIT_524288(WAIT_524288))
    standby_wake_chk_i (.aclk, .aresetn, .ext_wake, .sleep_exec, .int_request, .sleep_exception,
    .sleep_mode, .standby_mode, .settling, .core_resume, .rvalid, .rready, .rdata);

// [verif/core_model.sv]
// behavioural core issuing sleep instructions and interrupts
`timescale 1ns/1ns
module core_model (
    input wire logic aclk,
    input wire logic sleep_exception,
    input wire logic core_resume,
    output logic sleep_exec,
    output logic int_request
);
    int exc_count = 0;
    int resume_count = 0;
    initial begin
        sleep_exec = 1'b0;
        int_request = 1'b0;
    end
    // tally the one-cycle answers of the block
    always @(posedge aclk) begin
        if (sleep_exception === 1'b1) exc_count++;
        if (core_resume === 1'b1) resume_count++;
    end
    // one sleep instruction is a single-cycle pulse
    task automatic exec_sleep();
        @(posedge aclk);
        sleep_exec <= 1'b1;
        @(posedge aclk);
        sleep_exec <= 1'b0;
    endtask
    // interrupt held until the core is released; bounded so a hang cannot stall us
    task automatic interrupt(input int delay);
        int n;
        repeat (delay) @(posedge aclk);
        int_request <= 1'b1;
        for (n = 0; n < 8000 && core_resume !== 1'b1; n++) @(posedge aclk);
        int_request <= 1'b0;
    endtask
endmodule

// [verif/testbench.sv]
// self-checking bench for the standby wake timer
`timescale 1ns/1ns
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch at %0t got %h expected %h", $time, (got), (exp)); end end
module testbench;
    import standby_pkg::*;
    localparam int PW[6] = '{100, 200, 300, 400, 500, 600};
    localparam int SHORT[5] = '{64, 512, 1024, 2048, 4096};
    localparam int CODES[13] = '{5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 0, 16};
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, ext_wake = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, ctrl_model = '0, seed = 32'h0000_0026;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, sleep_exec, int_request, sleep_exception;
    logic sleep_mode, standby_mode, settling, core_resume, output_port_enable;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    int bad_count = 0;
    int samples_checked = 0;
    always #10 aclk = ~aclk;
    standby_wake_timer #(.WAIT_16384(PW[0]), .WAIT_32768(PW[1]), .WAIT_65536(PW[2]),
        .WAIT_131072(PW[3]), .WAIT_262144(PW[4]), .WAIT_524288(PW[5])) standby_wake_timer_i (
        .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .sleep_exec, .int_request, .ext_wake, .sleep_exception, .sleep_mode, .standby_mode,
        .settling, .core_resume, .output_port_enable);
    core_model core_model_i (.aclk, .sleep_exception, .core_resume, .sleep_exec, .int_request);
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic timed_out();
        bad_count++;
        $display("mismatch at %0t wait ran out", $time);
        report_and_stop();
    endtask
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // reference wait length per selector code; reserved codes take the longest
    function automatic int wait_len(input int code);
        if (code >= 5 && code <= 9) return SHORT[code - 5];
        if (code >= 10 && code <= 15) return PW[code - 10];
        return PW[5];
    endfunction
    // bus write: both halves offered at once, each dropped when taken
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (100) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        timed_out();
    endtask
    task automatic axi_rd(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (100) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        timed_out();
    endtask
    // control write and readback; bit 13 and bits 6..0 always read zero
    task automatic ctrl_rw(input logic [31:0] d);
        axi_wr(STANDBY_CONTROL_OFFSET, d);
        `CHECK(resp, RESP_OKAY)
        ctrl_model = d & 32'h0000_DF80;
        axi_rd(STANDBY_CONTROL_OFFSET);
        `CHECK(rd, ctrl_model)
        `CHECK(output_port_enable, ctrl_model[14])
    endtask
    // standby with an interrupt pending, then an external wake; settle length measured
    task automatic standby_run(input int code);
        int cnt;
        int n;
        ctrl_rw(32'h0000_8000 | 32'(code << 8));
        core_model_i.exec_sleep();
        @(negedge aclk);
        `CHECK(standby_mode, 1'b1)
        cnt = 0;
        fork
            core_model_i.interrupt(1);
            begin
                repeat (8) @(posedge aclk);
                `CHECK(standby_mode & ~settling, 1'b1)
                ext_wake <= 1'b1;
                for (n = 0; n < 8000 && core_resume !== 1'b1; n++) begin
                    @(posedge aclk);
                    if (settling === 1'b1) cnt++;
                end
                ext_wake <= 1'b0;
                if (n >= 8000) timed_out();
            end
        join
        `CHECK(cnt, wait_len(code))
        @(negedge aclk);
        `CHECK(standby_mode, 1'b0)
        $display("test standby code %0d done", code);
    endtask
    initial begin
        int i;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(STANDBY_CONTROL_OFFSET);
        `CHECK(rd, 32'h0000_4F00)
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            seed = next_rand(seed);
            ctrl_rw(seed[7] ? (seed & 32'hFFFF_7FFF) : seed);
        end
        axi_wr(32'h0000_0010, 32'hFFFF_FFFF);
        `CHECK(resp, RESP_SLVERR)
        axi_wr(POWER_STATUS_OFFSET, 32'hFFFF_FFFF);
        `CHECK(resp, RESP_SLVERR)
        axi_rd(32'h0000_0010);
        `CHECK({resp, rd}, {RESP_SLVERR, 32'h0000_0000})
        axi_rd(STANDBY_CONTROL_OFFSET);
        `CHECK(rd, ctrl_model)
        @(posedge aclk);
        ce <= 1'b0;
        @(negedge aclk);
        `CHECK({awready, wready, arready}, 3'h0)
        @(posedge aclk);
        ce <= 1'b1;
        $display("test registers done");
        ctrl_rw(32'h0000_0080);
        i = core_model_i.exc_count;
        core_model_i.exec_sleep();
        repeat (2) @(negedge aclk);
        `CHECK(core_model_i.exc_count == i + 1, 1'b1)
        `CHECK({sleep_mode, standby_mode}, 2'h0)
        core_model_i.exec_sleep();
        repeat (2) @(negedge aclk);
        `CHECK(core_model_i.exc_count == i + 2, 1'b1)
        axi_rd(STANDBY_CONTROL_OFFSET);
        `CHECK(rd, 32'h0000_0080)
        ctrl_rw(32'h0000_0000);
        $display("test exception done");
        core_model_i.exec_sleep();
        @(negedge aclk);
        `CHECK({sleep_mode, standby_mode}, 2'h2)
        axi_rd(POWER_STATUS_OFFSET);
        `CHECK(rd, 32'h0000_0001)
        i = core_model_i.resume_count;
        core_model_i.interrupt(4);
        @(negedge aclk);
        `CHECK(sleep_mode, 1'b0)
        `CHECK(core_model_i.resume_count == i + 1, 1'b1)
        $display("test sleep done");
        for (i = 0; i < 13; i++) standby_run(CODES[i]);
        report_and_stop();
    end
endmodule
